// *** core/spr_ctrl.sv ***
// module: snapshot command and rate pin edge monitor
`default_nettype none

module spr_ctrl
  import spr_pkg::*;
#(
  parameter int VALID_CYCLES = SPR_VALID_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_cmd_valid,
  input wire spr_pkg::spr_cmd_s link_cmd,
  output logic link_busy,
  output spr_pkg::spr_status_s link_rd_data,
  input wire logic rate_pin,
  output spr_pkg::spr_snap_s snap,
  output logic data_valid,
  output spr_pkg::spr_status_s status
);
  import spr_pkg::*;

  // ==================================================
  // state of the link domain
  typedef struct packed {
    spr_cmd_s cmd;
    logic req_tgl;
    spr_status_s rd;
  } spr_link_s;

  // ==================================================
  // state of the mclk domain
  typedef struct packed {
    logic pin_prev;
    logic rose;
    logic fell;
    logic [3:0] enables;
    logic ack_tgl;
    logic req_seen;
    spr_snap_s snap;
    logic [31:0] cnt;
    logic valid;
    logic armed;
    spr_status_s status;
  } spr_core_s;

  spr_link_s lk_q;
  spr_link_s lk_d;
  spr_core_s cr_q;
  spr_core_s cr_d;

  logic ack_sync;
  logic req_sync;
  logic pin_sync;
  logic [7:0] status_sync;

  // ==================================================
  // decoding used by both the command and the edge logic
  function automatic logic spr_is_reset_cmd(input logic [7:0] code);
    spr_is_reset_cmd = (code == SPR_CMD_FULL) || (code == SPR_CMD_BROADCAST);
  endfunction : spr_is_reset_cmd

  function automatic spr_snap_s spr_edge_snap(input logic rst_en, input logic keep_en);
    spr_snap_s s;
    s = '0;
    // resetting snapshot wins when both are enabled
    if (rst_en) begin
      s.copy = 1'b1;
      s.clear_accum = 1'b1;
    end else if (keep_en) begin
      s.copy = 1'b1;
    end
    s.activate = 1'b0;
    spr_edge_snap = s;
  endfunction : spr_edge_snap

  // ==================================================
  // crossings
  // ack toggle back into the link domain
  spr_sync #(.W(1)) u_ack_sync (
    .clk(link_clk),
    .rst_b(link_rst_b),
    .async_in(cr_q.ack_tgl),
    .sync_out(ack_sync)
  );

  // request toggle into the mclk domain
  spr_sync #(.W(1)) u_req_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .async_in(lk_q.req_tgl),
    .sync_out(req_sync)
  );

  // rate pin comes from another controller
  spr_sync #(.W(1)) u_pin_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .async_in(rate_pin),
    .sync_out(pin_sync)
  );

  // status bits are independent levels, each synchronised alone
  spr_sync #(.W(8)) u_status_sync (
    .clk(link_clk),
    .rst_b(link_rst_b),
    .async_in(cr_q.status),
    .sync_out(status_sync)
  );

  // ==================================================
  // link domain: capture a command and hand it over
  always_comb begin
    lk_d = lk_q;
    // a new command is taken only when the previous one was acknowledged
    if (link_cmd_valid && !link_busy) begin
      lk_d.cmd = link_cmd;
      lk_d.req_tgl = ~lk_q.req_tgl;
    end
    lk_d.rd = status_sync;
  end

  // link domain register
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign link_busy = lk_q.req_tgl ^ ack_sync;
  assign link_rd_data = lk_q.rd;

  // ==================================================
  // mclk domain: commands, pin edges and snapshot timing
  logic cmd_new;
  logic pin_rise;
  logic pin_fall;
  logic cmd_keep;
  logic cmd_reset;
  logic cmd_write;
  spr_snap_s edge_snap;

  always_comb begin
    cr_d = cr_q;
    // the command word is stable once its toggle has been synchronised
    cmd_new = req_sync ^ cr_q.req_seen;
    cmd_keep = cmd_new && (lk_q.cmd.code == SPR_CMD_KEEP_ACCUM)
               && !lk_q.cmd.write;
    cmd_reset = cmd_new && spr_is_reset_cmd(lk_q.cmd.code) && !lk_q.cmd.write;
    cmd_write = cmd_new && (lk_q.cmd.code == SPR_CMD_PIN_REG) && lk_q.cmd.write;
    cr_d.req_seen = req_sync;
    if (cmd_new) begin
      cr_d.ack_tgl = ~cr_q.ack_tgl;
    end

    // edges of the synchronised pin, one request each
    pin_rise = pin_sync && !cr_q.pin_prev;
    pin_fall = !pin_sync && cr_q.pin_prev;
    cr_d.pin_prev = pin_sync;
    edge_snap = '0;
    if (pin_rise) begin
      edge_snap = spr_edge_snap(cr_q.enables[3], cr_q.enables[2]);
    end else if (pin_fall) begin
      edge_snap = spr_edge_snap(cr_q.enables[1], cr_q.enables[0]);
    end

    // software writes the enable bits directly; they act on edges from the next mclk cycle
    if (cmd_write) begin
      cr_d.enables = lk_q.cmd.data[SPR_BIT_RST_RISE:SPR_BIT_KEEP_FALL];
    end

    // sticky flags: full and broadcast resetting commands clear, a same-cycle edge still sets
    if (cmd_reset) begin
      cr_d.rose = 1'b0;
      cr_d.fell = 1'b0;
    end
    if (pin_rise) begin
      cr_d.rose = 1'b1;
    end
    if (pin_fall) begin
      cr_d.fell = 1'b1;
    end

    // snapshot strobes to the result copy logic
    cr_d.snap = edge_snap;
    if (cmd_keep) begin
      cr_d.snap.copy = 1'b1;
    end
    if (cmd_reset) begin
      cr_d.snap.copy = 1'b1;
      cr_d.snap.clear_accum = 1'b1;
      cr_d.snap.activate = 1'b1;
    end

    // readable data settles after any snapshot; nothing is valid before the first one
    if (cr_d.snap.copy) begin
      cr_d.valid = 1'b0;
      cr_d.armed = 1'b1;
      cr_d.cnt = 32'(VALID_CYCLES - 1);
    end else if (!cr_q.valid && cr_q.armed) begin
      if (cr_q.cnt == 32'h0000_0000) begin
        cr_d.valid = cr_q.snap.copy ? 1'b0 : 1'b1;
      end else begin
        cr_d.cnt = cr_q.cnt - 32'h0000_0001;
      end
    end

    // live status image
    cr_d.status.live = pin_sync;
    cr_d.status.rose = cr_d.rose;
    cr_d.status.fell = cr_d.fell;
    cr_d.status.rst_rise = cr_d.enables[3];
    cr_d.status.keep_rise = cr_d.enables[2];
    cr_d.status.rst_fall = cr_d.enables[1];
    cr_d.status.keep_fall = cr_d.enables[0];
    cr_d.status.unused = 1'b0;
  end

  // mclk domain register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cr_q <= '0;
      cr_q.cnt <= SPR_CNT_RESET;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign snap = cr_q.snap;
  assign data_valid = cr_q.valid;
  assign status = cr_q.status;
endmodule : spr_ctrl
`default_nettype wire

// *** core/spr_pkg.sv ***
// package: constants and carriers for the slow pin refresh control block
`default_nettype none
package spr_pkg;
  // ==================================================
  // command codes
  localparam logic [7:0] SPR_CMD_KEEP_ACCUM = 8'h1f;   // snapshot_keep_accum_cmd
  localparam logic [7:0] SPR_CMD_BROADCAST = 8'h1e;    // broadcast resetting snapshot
  localparam logic [7:0] SPR_CMD_FULL = 8'h00;         // full resetting snapshot
  localparam logic [7:0] SPR_CMD_PIN_REG = 8'h20;      // rate_pin_status_control access

  // ==================================================
  // rate_pin_status_control field positions
  localparam int SPR_BIT_LIVE = 7;
  localparam int SPR_BIT_ROSE = 6;
  localparam int SPR_BIT_FELL = 5;
  localparam int SPR_BIT_RST_RISE = 4;
  localparam int SPR_BIT_KEEP_RISE = 3;
  localparam int SPR_BIT_RST_FALL = 2;
  localparam int SPR_BIT_KEEP_FALL = 1;
  localparam int SPR_BIT_UNUSED = 0;
  localparam logic [7:0] SPR_PIN_REG_RESET = 8'h00;

  // ==================================================
  // timing: readable data settles this long after a snapshot
  localparam int SPR_VALID_MS = 1;
  localparam int SPR_MCLK_HZ = 50000000;
  localparam int SPR_VALID_CYCLES = SPR_VALID_MS * (SPR_MCLK_HZ / 1000);
  localparam logic [31:0] SPR_CNT_RESET = 32'h0000_0000;

  // ==================================================
  // carriers
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
    logic write;
  } spr_cmd_s;

  typedef struct packed {
    logic live;
    logic rose;
    logic fell;
    logic rst_rise;
    logic keep_rise;
    logic rst_fall;
    logic keep_fall;
    logic unused;
  } spr_status_s;

  typedef struct packed {
    logic copy;
    logic clear_accum;
    logic activate;
  } spr_snap_s;
endpackage : spr_pkg
`default_nettype wire

// *** core/spr_sync.sv ***
// module: two flip-flop synchroniser for independent level bits
`default_nettype none
module spr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import spr_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } spr_sync_s;

  spr_sync_s st_q;
  spr_sync_s st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule : spr_sync
`default_nettype wire

// *** verif/spr_chk.sv ***
// checker: snapshot strobes, settle window and pin status
`default_nettype none
module spr_chk
#(
  parameter int VALID_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_cmd_valid,
  input wire spr_pkg::spr_cmd_s link_cmd,
  input wire logic link_busy,
  input wire spr_pkg::spr_status_s link_rd_data,
  input wire logic rate_pin,
  input wire spr_pkg::spr_snap_s snap,
  input wire logic data_valid,
  input wire spr_pkg::spr_status_s status
);
  import spr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  int unsigned c_q;
  logic seen_q;
  // ==================================================
  // cycles since the last copy strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      c_q <= 0;
      seen_q <= 1'b0;
    end else begin
      c_q <= snap.copy ? 0 : (c_q < 1000 ? c_q + 1 : c_q);
      seen_q <= seen_q | snap.copy;
    end
  end
  unused_zero_a: assert property (!status.unused) else $error("bit 0 set");
  live_lag_a: assert property (status.live == $past(rate_pin, 3)) else $error("live bit");
  clear_copy_a: assert property (snap.clear_accum |-> snap.copy) else $error("clear alone");
  act_clear_a: assert property (snap.activate |-> snap.clear_accum) else $error("bad activate");
  valid_early_a: assert property (data_valid |-> seen_q && c_q + 1 >= VALID_CYCLES)
    else $error("valid early");
  valid_late_a: assert property (seen_q && c_q == VALID_CYCLES - 1 |-> data_valid)
    else $error("valid late");
  fell_clr_a: assert property ($fell(status.fell) |-> snap.activate || $past(snap.activate))
    else $error("fell cleared");
  rose_clr_a: assert property ($fell(status.rose) |-> snap.activate || $past(snap.activate))
    else $error("rose cleared");
  rise_kind_a: assert property ($rose(status.rose) |-> snap.clear_accum == status.rst_rise
    && snap.copy == (status.rst_rise | status.keep_rise)) else $error("rise snapshot");
endmodule : spr_chk
bind spr_ctrl spr_chk #(.VALID_CYCLES(VALID_CYCLES)) chk_u (
  .mclk(mclk),
  .rst_b(rst_b),
  .link_clk(link_clk),
  .link_rst_b(link_rst_b),
  .link_cmd_valid(link_cmd_valid),
  .link_cmd(link_cmd),
  .link_busy(link_busy),
  .link_rd_data(link_rd_data),
  .rate_pin(rate_pin),
  .snap(snap),
  .data_valid(data_valid),
  .status(status)
);
`default_nettype wire

// *** verif/spr_host.sv ***
// partner: host that issues commands over the link
`default_nettype none
module spr_host (
  input wire logic link_clk,
  input wire logic link_busy,
  output logic link_cmd_valid,
  output spr_pkg::spr_cmd_s link_cmd
);
  import spr_pkg::*;
  initial begin
    link_cmd_valid = 1'b0;
    link_cmd = '0;
  end
  // align to a falling edge, wait g cycles and a free link, present one command
  // across one rising edge, check it was taken, then wait out busy
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic w, input int g,
    output logic ok);
    int n;
    logic taken;
    n = 0;
    repeat (g + 1) @(negedge link_clk);
    while (link_busy !== 1'b0 && n < 60) begin
      @(negedge link_clk);
      n++;
    end
    link_cmd = spr_cmd_s'{c, d, w};
    link_cmd_valid = 1'b1;
    @(negedge link_clk);
    taken = (link_busy === 1'b1);
    link_cmd_valid = 1'b0;
    link_cmd = ~link_cmd;
    @(negedge link_clk);
    while (link_busy !== 1'b0 && n < 60) begin
      @(negedge link_clk);
      n++;
    end
    ok = (n < 60) && taken;
  endtask : send
endmodule : spr_host
`default_nettype wire

// *** verif/test_slow_pin_refresh_control.sv ***
// testbench: snapshot commands and rate pin edges
`default_nettype none
module test_slow_pin_refresh_control;
  timeunit 1ns;
  timeprecision 100ps;
  import spr_pkg::*;
  logic mclk = 0, rst_b = 0, link_clk = 0, link_rst_b = 0, link_run = 1, rate_pin = 0;
  logic link_cmd_valid, link_busy, data_valid, ok;
  spr_cmd_s link_cmd;
  spr_status_s link_rd_data, status, st_e;
  spr_snap_s snap, k;
  int errors = 0, checks = 0, n;
  logic [7:0] en [4] = '{8'h12, 8'h0c, 8'h00, 8'h1e};
  always #10 mclk = ~mclk;
  // link clock stands still between transfers
  always #7.5 if (link_run || link_clk) link_clk = ~link_clk;
  spr_ctrl #(.VALID_CYCLES(20)) dut_u (.mclk(mclk), .rst_b(rst_b), .link_clk(link_clk),
    .link_rst_b(link_rst_b), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
    .link_busy(link_busy), .link_rd_data(link_rd_data), .rate_pin(rate_pin), .snap(snap),
    .data_valid(data_valid), .status(status));
  spr_host host_u (.link_clk(link_clk), .link_busy(link_busy),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // count snapshot pulses over a window, merging their kinds
  task automatic watch;
    n = 0;
    k = '0;
    repeat (40) begin
      @(negedge mclk);
      if (snap.copy === 1'b1) n++;
      k = k | snap;
    end
  endtask : watch
  // issue a command while watching the snapshot strobes
  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic w, input int g);
    link_run = 1'b1;
    fork
      host_u.send(c, d, w, g, ok);
      watch();
    join
    link_run = 1'b0;
    if (ok !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask : cmd
  // keep snapshot: copy only, results valid after the settle time
  task automatic t_keep;
    chk(8'(data_valid), 8'h00);
    cmd(SPR_CMD_KEEP_ACCUM, 8'h00, 1'b0, 0);
    chk(8'(n), 8'h01);
    chk(8'(k), 8'h04);
    chk(8'(data_valid), 8'h01);
  endtask : t_keep
  // resetting snapshot: all strobes, flags cleared, enables kept
  task automatic t_full(input logic [7:0] c);
    cmd(c, 8'h00, 1'b0, 5);
    chk(8'(k), 8'h07);
    st_e.rose = 1'b0;
    st_e.fell = 1'b0;
    chk(status, st_e);
  endtask : t_full
  // pin edges under each enable mix
  task automatic t_edges;
    for (int i = 0; i < 4; i++) begin
      cmd(SPR_CMD_PIN_REG, en[i], 1'b1, i);
      chk(8'(n), 8'h00);
      st_e = (st_e & 8'he0) | (en[i] & 8'h1e);
      chk(status, st_e);
      rate_pin = 1'b1;
      watch();
      st_e.live = 1'b1;
      st_e.rose = 1'b1;
      chk(8'(n), 8'(|en[i][4:3]));
      chk(8'(k), {5'h0, |en[i][4:3], en[i][4], 1'b0});
      chk(status, st_e);
      link_run = 1'b1;
      rate_pin = 1'b0;
      watch();
      st_e.live = 1'b0;
      st_e.fell = 1'b1;
      chk(8'(n), 8'(|en[i][2:1]));
      chk(8'(k), {5'h0, |en[i][2:1], en[i][2], 1'b0});
      chk(link_rd_data, st_e);
      link_run = 1'b0;
    end
  endtask : t_edges
  initial begin
    st_e = '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    link_rst_b = 1'b1;
    link_run = 1'b0;
    t_keep();
    t_full(SPR_CMD_FULL);
    t_edges();
    t_full(SPR_CMD_BROADCAST);
    print_verdict();
  end
endmodule : test_slow_pin_refresh_control
`default_nettype wire
